// [verilog/rwcc_defines.svh]
`ifndef RWCC_DEFINES_SVH
`define RWCC_DEFINES_SVH

// ==========================================================================
// Register offsets (byte addresses on the APB)
`define RWCC_OFS_CAUSE      12'h000
`define RWCC_OFS_CTRL       12'h004
`define RWCC_OFS_WDOG_KICK  12'h008
`define RWCC_OFS_TICK_DIV   12'h00C
`define RWCC_OFS_STATUS     12'h010

// ==========================================================================
// Field positions
`define RWCC_CAUSE_POR_BIT   0
`define RWCC_CAUSE_WDOG_BIT  1
`define RWCC_CAUSE_PC_BIT    2
`define RWCC_CAUSE_SW_BIT    3
`define RWCC_CAUSE_DIP_BIT   4
`define RWCC_CTRL_SWRST_BIT  0
`define RWCC_STAT_AON_BIT    0
`define RWCC_STAT_CORE_BIT   1
`define RWCC_STAT_PAD_BIT    2
`define RWCC_STAT_REG_BIT    3
`define RWCC_STAT_WCNT_LSB   16

// ==========================================================================
// Reset values
`define RWCC_CAUSE_RESET     5'h01
`define RWCC_TICK_DIV_RESET  8'h0A

// ==========================================================================
// Timing counts
`define RWCC_RC_PULSES       3
`define RWCC_XTAL_EDGES      1024
`define RWCC_RC_FREQ_HZ      10000
`define RWCC_WDOG_TIMEOUT_MS 2000

`endif

// [verilog/rwcc_pkg.sv]
package rwcc_pkg;

  // ========================================================================
  // APB carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rwcc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rwcc_apb_rsp_t;

  // ========================================================================
  // Sequencer states and reset causes
  typedef enum logic [2:0] {
    RWCC_ST_AON_RST,
    RWCC_ST_CORE_WAIT,
    RWCC_ST_CORE_CNT,
    RWCC_ST_RUN
  } rwcc_state_t;

  typedef struct packed {
    logic dip;
    logic sw;
    logic pc;
    logic wdog;
    logic por;
  } rwcc_cause_t;

endpackage

// [verilog/rwcc_sync.sv]
`timescale 1ns/100ps

// ==========================================================================
// Two-stage synchroniser for pins and foreign clocks
module rwcc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_resetn,
  // Data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule // rwcc_sync

// [verilog/rwcc_top.sv]
`timescale 1ns/100ps
`include "rwcc_defines.svh"

// Contract
// [R1] Log cause of each reset for software
// [R2] Five causes: POR, watchdog, PC, software, dip
// [R3] Hold always-on reset: pad ok, three RC pulses
// [R4] Hold core reset while regulator below threshold
// [R5] Count 1024 crystal edges before core release
// [R6] Free RC clock, programmable divider to 1kHz
// [R7] Divided tick clocks the sleep timer
// [R8] Watchdog on RC clock, resets near 2s
// [R9] Watchdog reset never reaches a pin
// [R10] Firmware may restart the watchdog count
// [R11] Host has no path to watchdog
// [R12] Restart clears counter; counter reaches limit
module rwcc_top #(
  parameter int WDOG_TIMEOUT_MS = `RWCC_WDOG_TIMEOUT_MS,
  parameter int RC_FREQ_HZ      = `RWCC_RC_FREQ_HZ,
  parameter int XTAL_EDGES      = `RWCC_XTAL_EDGES,
  parameter int RC_PULSES       = `RWCC_RC_PULSES
) (
  // Clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_resetn,
  // Analog and oscillator pins
  input  wire logic                    i_pad_supply_ok,
  input  wire logic                    i_reg_supply_ok,
  input  wire logic                    i_rc_osc,
  input  wire logic                    i_xtal_osc,
  // Core events
  input  wire logic                    i_pc_rollover,
  // Firmware APB port
  input  wire rwcc_pkg::rwcc_apb_req_t i_apb,
  output rwcc_pkg::rwcc_apb_rsp_t      o_apb,
  // Reset and tick outputs
  output logic                         o_aon_resetn,
  output logic                         o_core_resetn,
  output logic                         o_sleep_tick
);

  import rwcc_pkg::*;

  // ========================================================================
  // Derived widths and counts
  localparam int WDOG_LIMIT_I = (WDOG_TIMEOUT_MS * RC_FREQ_HZ) / 1000;
  localparam int WDOG_W       = $clog2(WDOG_LIMIT_I + 1);
  localparam int XTAL_W       = $clog2(XTAL_EDGES + 1);
  localparam int RCP_W        = $clog2(RC_PULSES + 1);
  localparam logic [WDOG_W-1:0] WDOG_LIMIT = WDOG_W'(WDOG_LIMIT_I);
  localparam logic [XTAL_W-1:0] XTAL_LAST  = XTAL_W'(XTAL_EDGES - 1);
  localparam logic [RCP_W-1:0]  RCP_LAST   = RCP_W'(RC_PULSES);

  // Address match used by both the read mux and the write strobes
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
    return (a == ofs);
  endfunction

  // ========================================================================
  // Pin synchronisers and edge detection
  logic [3:0] sync_w;
  logic       pad_ok;
  logic       reg_ok;
  logic       rc_s;
  logic       xtal_s;
  logic       rc_prev_q;
  logic       xtal_prev_q;
  logic       rc_rise;
  logic       xtal_rise;

  rwcc_sync #(
    .W (4)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_async   ({i_xtal_osc, i_rc_osc, i_reg_supply_ok, i_pad_supply_ok}),
    .o_sync    (sync_w)
  );

  assign pad_ok = sync_w[0];
  assign reg_ok = sync_w[1];
  assign rc_s   = sync_w[2];
  assign xtal_s = sync_w[3];

  // Edge history taken from the synchronised copies only
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rc_prev_q   <= 1'b0;
      xtal_prev_q <= 1'b0;
    end else begin
      rc_prev_q   <= rc_s;
      xtal_prev_q <= xtal_s;
    end
  end

  // The crystal is faster than the reference clock, so some of its edges
  // alias away; the count then only stretches the core release, never shortens it
  assign rc_rise   = rc_s & ~rc_prev_q;
  assign xtal_rise = xtal_s & ~xtal_prev_q;

  // ========================================================================
  // APB decode
  logic apb_acc;
  logic apb_wr;
  logic mapped;
  logic wr_ctrl;
  logic wr_kick;
  logic wr_div;

  assign apb_acc = i_apb.psel & i_apb.penable;
  assign apb_wr  = apb_acc & i_apb.pwrite;
  assign mapped  = addr_is(i_apb.paddr, `RWCC_OFS_CAUSE)
                 | addr_is(i_apb.paddr, `RWCC_OFS_CTRL)
                 | addr_is(i_apb.paddr, `RWCC_OFS_WDOG_KICK)
                 | addr_is(i_apb.paddr, `RWCC_OFS_TICK_DIV)
                 | addr_is(i_apb.paddr, `RWCC_OFS_STATUS);
  assign wr_ctrl = apb_wr & addr_is(i_apb.paddr, `RWCC_OFS_CTRL);
  assign wr_kick = apb_wr & addr_is(i_apb.paddr, `RWCC_OFS_WDOG_KICK);
  assign wr_div  = apb_wr & addr_is(i_apb.paddr, `RWCC_OFS_TICK_DIV);

  // ========================================================================
  // Reset sequencer
  rwcc_state_t       state_q;
  logic [RCP_W-1:0]  rcp_cnt_q;
  logic [XTAL_W-1:0] xtal_cnt_q;
  logic [WDOG_W-1:0] wdog_cnt_q;
  logic              wdog_fire;
  logic              sw_req;
  logic              pc_req;
  logic              run;

  assign run       = (state_q == RWCC_ST_RUN);
  assign wdog_fire = run & (wdog_cnt_q >= WDOG_LIMIT);
  assign sw_req    = run & wr_ctrl & i_apb.pwdata[`RWCC_CTRL_SWRST_BIT];
  assign pc_req    = run & i_pc_rollover;

  // Loss of the pad supply restarts both reset domains, a core event only the core
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= RWCC_ST_AON_RST;
    end else if (!pad_ok) begin
      state_q <= RWCC_ST_AON_RST;                                   // [R3]
    end else begin
      unique case (state_q)
        RWCC_ST_AON_RST: begin
          if (rcp_cnt_q == RCP_LAST) state_q <= RWCC_ST_CORE_WAIT;   // [R3]
        end
        RWCC_ST_CORE_WAIT: begin
          if (reg_ok) state_q <= RWCC_ST_CORE_CNT;                   // [R4]
        end
        RWCC_ST_CORE_CNT: begin
          if (!reg_ok) begin
            state_q <= RWCC_ST_CORE_WAIT;                            // [R4]
          end else if (xtal_rise && xtal_cnt_q == XTAL_LAST) begin
            state_q <= RWCC_ST_RUN;                                  // [R5]
          end
        end
        RWCC_ST_RUN: begin
          if (!reg_ok || wdog_fire || sw_req || pc_req) begin
            state_q <= RWCC_ST_CORE_WAIT;                            // [R8]
          end
        end
        // Unused codes of the 3-bit state fall back to a full restart
        default: begin
          state_q <= RWCC_ST_AON_RST;
        end
      endcase
    end
  end

  // RC pulses counted only with the pad supply up
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rcp_cnt_q <= '0;
    end else if (!pad_ok) begin
      rcp_cnt_q <= '0;
    end else if (state_q == RWCC_ST_AON_RST && rc_rise && rcp_cnt_q != RCP_LAST) begin
      rcp_cnt_q <= rcp_cnt_q + RCP_W'(1);                            // [R3]
    end
  end

  // Crystal edge counter restarts whenever the regulator is not good
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      xtal_cnt_q <= '0;
    end else if (state_q != RWCC_ST_CORE_CNT || !reg_ok) begin
      xtal_cnt_q <= '0;
    end else if (xtal_rise) begin
      xtal_cnt_q <= xtal_cnt_q + XTAL_W'(1);                         // [R5]
    end
  end

  // Reset outputs; the watchdog reset only acts through the core reset
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_aon_resetn  <= 1'b0;
      o_core_resetn <= 1'b0;
    end else begin
      o_aon_resetn  <= pad_ok && (state_q != RWCC_ST_AON_RST);       // [R3]
      o_core_resetn <= pad_ok && reg_ok && run && !wdog_fire
                       && !sw_req && !pc_req;                        // [R4] [R9]
    end
  end

  // ========================================================================
  // Reset cause, one-hot, rewritten by every new reset
  rwcc_cause_t cause_q;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cause_q <= rwcc_cause_t'(`RWCC_CAUSE_RESET);                   // [R1]
    end else if (!pad_ok) begin
      cause_q <= rwcc_cause_t'(`RWCC_CAUSE_RESET);                   // [R2]
    end else if (run && !reg_ok) begin
      cause_q <= '{dip: 1'b1, default: 1'b0};                        // [R2]
    end else if (wdog_fire) begin
      cause_q <= '{wdog: 1'b1, default: 1'b0};                       // [R2]
    end else if (pc_req) begin
      cause_q <= '{pc: 1'b1, default: 1'b0};                         // [R2]
    end else if (sw_req) begin
      cause_q <= '{sw: 1'b1, default: 1'b0};                         // [R1]
    end
  end

  // ========================================================================
  // Watchdog, counted in RC edges; only firmware can touch it
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wdog_cnt_q <= '0;
    end else if (!run || wr_kick) begin
      wdog_cnt_q <= '0;                                              // [R10] [R12]
    end else if (rc_rise && wdog_cnt_q < WDOG_LIMIT) begin
      wdog_cnt_q <= wdog_cnt_q + WDOG_W'(1);                         // [R8] [R12]
    end
  end
  // No host port exists on this block, so nothing else reaches the count [R11]

  // ========================================================================
  // Calibrated tick divider on the free-running RC clock
  logic [7:0] div_q;
  logic [7:0] div_cnt_q;
  logic [7:0] div_last;

  // A ratio of zero would wrap to a tick every 256 RC edges, so it behaves as one
  assign div_last = (div_q == 8'h00) ? 8'h00 : div_q - 8'h01;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_q <= `RWCC_TICK_DIV_RESET;
    end else if (wr_div) begin
      div_q <= i_apb.pwdata[7:0];                                    // [R6]
    end
  end

  // Tick is one reference cycle wide, once per div_q RC edges
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_cnt_q    <= 8'h00;
      o_sleep_tick <= 1'b0;
    end else begin
      o_sleep_tick <= 1'b0;
      if (rc_rise) begin
        if (div_cnt_q >= div_last) begin
          div_cnt_q    <= 8'h00;
          o_sleep_tick <= 1'b1;                                      // [R6] [R7]
        end else begin
          div_cnt_q <= div_cnt_q + 8'h01;
        end
      end
    end
  end

  // ========================================================================
  // APB read data and response; zero wait states
  logic [31:0] rd_d;
  logic [31:0] rd_q;

  always_comb begin
    rd_d = 32'h0000_0000;
    if (addr_is(i_apb.paddr, `RWCC_OFS_CAUSE)) begin
      rd_d[4:0] = cause_q;                                           // [R1]
    end else if (addr_is(i_apb.paddr, `RWCC_OFS_TICK_DIV)) begin
      rd_d[7:0] = div_q;
    end else if (addr_is(i_apb.paddr, `RWCC_OFS_STATUS)) begin
      rd_d[`RWCC_STAT_AON_BIT]  = o_aon_resetn;
      rd_d[`RWCC_STAT_CORE_BIT] = o_core_resetn;
      rd_d[`RWCC_STAT_PAD_BIT]  = pad_ok;
      rd_d[`RWCC_STAT_REG_BIT]  = reg_ok;
      rd_d[`RWCC_STAT_WCNT_LSB +: WDOG_W] = wdog_cnt_q;
    end
  end

  assign o_apb.pready  = 1'b1;
  assign o_apb.pslverr = apb_acc & ~mapped;
  assign o_apb.prdata  = rd_q;

  // Read data is registered in the setup cycle, so the access phase still
  // answers at once; the trade-off is a value one cycle old
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_q <= 32'h0000_0000;
    end else if (i_apb.psel && !i_apb.penable && !i_apb.pwrite) begin
      rd_q <= rd_d;
    end else begin
      rd_q <= 32'h0000_0000;                                         // Zero outside reads
    end
  end

endmodule // rwcc_top

// [verif/rwcc_top_assertions.sv]
`timescale 1ns/100ps
// ==========================================
// Port-level checks of sequencing, tick and register bus
module rwcc_checker #(
  parameter int WDOG_TIMEOUT_MS = 2000,
  parameter int RC_FREQ_HZ      = 10000,
  parameter int XTAL_EDGES      = 1024,
  parameter int RC_PULSES       = 3
) (
  // Clock and reset
  input wire logic                    i_ref_clk,
  input wire logic                    i_resetn,
  // Pins and events
  input wire logic                    i_pad_supply_ok,
  input wire logic                    i_reg_supply_ok,
  input wire logic                    i_rc_osc,
  input wire logic                    i_xtal_osc,
  input wire logic                    i_pc_rollover,
  // Register bus
  input wire rwcc_pkg::rwcc_apb_req_t i_apb,
  input wire rwcc_pkg::rwcc_apb_rsp_t o_apb,
  // Outputs
  input wire logic                    o_aon_resetn,
  input wire logic                    o_core_resetn,
  input wire logic                    o_sleep_tick
);
  import rwcc_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // Access phase and its read variant
  sequence s_acc;
    i_apb.psel && i_apb.penable;
  endsequence
  sequence s_rd(logic [11:0] a);
    s_acc ##0 (!i_apb.pwrite && i_apb.paddr == a);
  endsequence
  logic mapped;
  // Word offsets the block decodes
  assign mapped = i_apb.paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
  AST_PREADY: assert property (s_acc |-> o_apb.pready)
    else $error("pready low in access phase");
  AST_CAUSE_ONEHOT: assert property (s_rd(12'h000) |->
    $onehot(o_apb.prdata[4:0]) && o_apb.prdata[31:5] == 27'h000_0000)
    else $error("cause read not one-hot");
  AST_UNMAPPED: assert property (s_acc ##0 !mapped |->
    o_apb.pslverr && o_apb.prdata == 32'h0000_0000) else $error("unmapped access accepted");
  AST_CORE_UNDER_AON: assert property (!o_aon_resetn |-> !o_core_resetn)
    else $error("core released before always-on domain");
  // Sync takes two edges, the state a third
  AST_AON_PAD: assert property (!i_pad_supply_ok [*5] |-> !o_aon_resetn)
    else $error("always-on domain out of reset without pad supply");
  AST_CORE_REG: assert property (!i_reg_supply_ok [*5] |-> !o_core_resetn)
    else $error("core out of reset without regulator");
  AST_CORE_RELEASE: assert property ($rose(o_core_resetn) |->
    $past(o_aon_resetn, 16) && i_reg_supply_ok) else $error("core released too early");
  AST_TICK_PULSE: assert property (o_sleep_tick |=> !o_sleep_tick)
    else $error("tick wider than one cycle");
  AST_TICK_RC: assert property (o_sleep_tick |-> i_rc_osc)
    else $error("tick not tied to an oscillator rise");
endmodule // rwcc_checker

// [verif/rwcc_top_bench.sv]
`timescale 1ns/100ps
module rwcc_top_bench;
  import rwcc_pkg::*;
  localparam int WMS = 2;
  localparam int XE  = 8;
  localparam int LIM = WMS * 10;  // RC rises to time-out at 10 kHz
  logic          clk = 0, rstn = 0, pad = 0, reg_ok = 0, rc = 0, xt = 0, pc = 0;
  logic          aon, core, tick, er;
  logic [31:0]   rd;
  rwcc_apb_req_t req = '0;
  rwcc_apb_rsp_t rsp;
  int            bad_count = 0, n_checks = 0, rcn = 0, xtn = 0, ph = 0, cf = 0;
  int            seed = 32'h0000_4f9a, d, r0, x0, f0;

  rwcc_top #(.WDOG_TIMEOUT_MS(WMS), .XTAL_EDGES(XE)) i_dut (.i_ref_clk(clk),
    .i_resetn(rstn), .i_pad_supply_ok(pad), .i_reg_supply_ok(reg_ok), .i_rc_osc(rc),
    .i_xtal_osc(xt), .i_pc_rollover(pc), .i_apb(req), .o_apb(rsp),
    .o_aon_resetn(aon), .o_core_resetn(core), .o_sleep_tick(tick));

  // ==========================================
  // Clock, oscillators and edge counters
  always #25 clk = ~clk;
  // Crystal kept at 5 MHz so no edge aliases in the synchroniser
  always @(posedge clk) begin
    ph <= ph + 1;
    if (ph % 10 == 9) rc <= ~rc;
    if (ph % 10 == 9 && !rc) rcn <= rcn + 1;
    if (ph % 2 == 1) xt <= ~xt;
    if (ph % 2 == 1 && !xt) xtn <= xtn + 1;
  end
  always @(negedge core) cf++;

  // ==========================================
  // Shared tasks
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer, held until pready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    req <= {1'b1, 1'b0, w, a, wd};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  // Unbounded wait for core (0), always-on (1) or tick (2) to reach v
  // Only the hang guard ends a stuck wait, so a stuck wait always counts as a failure
  task wt(input int s, input logic v);
    while ((s == 0 ? core : s == 1 ? aon : tick) !== v) begin
      @(posedge clk);
    end
  endtask
  // Always-on release, optional held-core check, then core release
  task pup(input bit hold);
    r0 = rcn;
    wt(1, 1);
    chk("rc pulses", rcn - r0 >= 3, 1);
    if (hold) begin
      repeat (200) @(posedge clk);
      chk("core held", core, 0);
      reg_ok <= 1'b1;
    end
    x0 = xtn;
    wt(0, 1);
    chk("xtal edges", xtn - x0 >= XE, 1);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    #(60000 * 50);
    bad_count++;
    end_sim;
  end

  // ==========================================
  // Test sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    apb(0, 12'h000, 0);
    chk("cause reset", rd, 32'h0000_0001);
    apb(0, 12'h00C, 0);
    chk("div reset", rd, 32'h0000_000A);
    apb(0, 12'h010, 0);
    chk("status reset", rd, 32'h0000_0000);
    pad <= 1'b1;
    pup(1);
    $display("power-up done");
    // Divider ratios, zero acting as one
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 0 : 2 + ({$random(seed)} % 4);
      apb(1, 12'h00C, d);
      apb(0, 12'h00C, 0);
      chk("div read", rd, d);
      wt(2, 1);
      wt(2, 0);
      r0 = rcn;
      wt(2, 1);
      chk("rises per tick", rcn - r0, (d == 0) ? 1 : d);
      // Kick here too, or the tick runs alone would outlast the time-out
      apb(1, 12'h008, 32'h0000_0000);
    end
    $display("tick done");
    // Kicks keep the core alive, then a time-out
    f0 = cf;
    repeat (5) begin
      repeat (200) @(posedge clk);
      apb(1, 12'h008, 32'h0000_0000);
    end
    chk("kicked", cf - f0, 0);
    r0 = rcn;
    wt(0, 0);
    chk("wdog rises", rcn - r0 >= LIM - 1 && rcn - r0 <= LIM, 1);
    wt(0, 1);
    apb(0, 12'h000, 0);
    chk("cause wdog", rd, 32'h0000_0002);
    $display("watchdog done");
    // Control write without bit0, cause write and unmapped access
    f0 = cf;
    apb(1, 12'h004, 32'h0000_0000);
    apb(1, 12'h000, 32'hFFFF_FFFF);
    apb(0, 12'h000, 0);
    chk("cause kept", rd, 32'h0000_0002);
    apb(0, 12'h014, 0);
    chk("unmapped err", er, 1);
    chk("no reset", cf - f0, 0);
    // Software, PC rollover and core dip causes
    for (int k = 0; k < 3; k++) begin
      case (k)
        0: apb(1, 12'h004, 32'h0000_0001);
        1: begin
          @(posedge clk);
          pc <= 1'b1;
          @(posedge clk);
          pc <= 1'b0;
        end
        default: begin
          @(posedge clk);
          reg_ok <= 1'b0;
          repeat (8) @(posedge clk);
          reg_ok <= 1'b1;
        end
      endcase
      wt(0, 0);
      wt(0, 1);
      apb(0, 12'h000, 0);
      chk("cause event", rd, 32'h0000_0008 >> k << (k == 2 ? 3 : 0));
    end
    $display("causes done");
    // Pad supply loss
    pad <= 1'b0;
    repeat (6) @(posedge clk);
    chk("aon low", aon, 0);
    pad <= 1'b1;
    pup(0);
    apb(0, 12'h000, 0);
    chk("cause por", rd, 32'h0000_0001);
    $display("power-on done");
    end_sim;
  end
endmodule // rwcc_top_bench

bind rwcc_top rwcc_checker #(.WDOG_TIMEOUT_MS(WDOG_TIMEOUT_MS), .RC_FREQ_HZ(RC_FREQ_HZ),
  .XTAL_EDGES(XTAL_EDGES), .RC_PULSES(RC_PULSES)) i_chk (.i_ref_clk(i_ref_clk),
  .i_resetn(i_resetn), .i_pad_supply_ok(i_pad_supply_ok), .i_reg_supply_ok(i_reg_supply_ok),
  .i_rc_osc(i_rc_osc), .i_xtal_osc(i_xtal_osc), .i_pc_rollover(i_pc_rollover),
  .i_apb(i_apb), .o_apb(o_apb), .o_aon_resetn(o_aon_resetn),
  .o_core_resetn(o_core_resetn), .o_sleep_tick(o_sleep_tick));
